/* File: hw/crpc_pkg.sv */
// package for the clock, power-state and reset controller
`default_nettype none
package crpc_pkg;
  // bus clock and low-power oscillator figures
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int LP_OSC_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int LP_DIV = LP_OSC_HZ / RTC_TICK_HZ;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0C;
  // field positions
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_STANDBY_BIT = 1;
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_PWRFAIL_BIT = 1;
  localparam int CAUSE_USER_BIT = 2;
  // reset values and the illegal peripheral divide code
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [2:0] CAUSE_RESET = 3'h0;
  localparam logic [1:0] PDIV_ILLEGAL = 2'h3;
  // power states, gray along standby -> run -> halt
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b11
  } crpc_state_t;
  // software control word
  typedef struct packed {
    logic lcd8;
    logic hgate;
    logic [1:0] pdiv;
    logic [1:0] hdiv;
  } crpc_ctrl_t;
  // clock and oscillator enables driven to the clock tree
  typedef struct packed {
    logic main_osc;
    logic system_pll;
    logic usb_pll;
    logic periph_ref;
    logic prog_div;
    logic core;
    logic display;
  } crpc_clk_en_t;
  // latched reset cause
  typedef struct packed {
    logic user;
    logic pwrfail;
    logic por;
  } crpc_cause_t;
endpackage : crpc_pkg
`default_nettype wire

/* File: hw/crpc_top.sv */
// clock, power-state and reset controller with wishbone register slave
// Functional notes
// - bus clock is core clock divided 1..4
// - peripheral clock is bus clock divided 2/4/8
// - software gate stops the bus clock
// - low-power clock ripple-divided to 1 Hz tick
// - low-power clock always runs, drives state logic
// - usb pll runs independent of core dividers
// - core, bus, peripheral clocks from system pll
// - main oscillator feeds plls, peripherals, programmable divider
// - run state enables every clock including core
// - halt stops core clock, rest keeps running
// - standby kills display and main oscillator
// - gating extent follows the power state
// - any reset input asserts system reset
// - power-on reset clears system and retained state, cause reads por only
// - fail/user reset spares sdram config and rtc
// - self-refresh requested during fail/user reset only
// - reset release enters standby
// - reset cause readable by software
// - standby parks shared pin low in 8-bit mode
`timescale 1ns/1ps
`default_nettype none
module crpc_top #(
  parameter int LP_DIV = crpc_pkg::LP_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external reset inputs, active low
  input wire logic power_on_reset_n_i,
  input wire logic power_fail_reset_n_i,
  input wire logic user_reset_n_i,
  // low-power oscillator level and wake event
  input wire logic lp_osc_i,
  input wire logic wake_i,
  // port logic's own drive of the shared pin
  input wire logic port_e0_drive_i,
  input wire logic port_e0_drive_oe_n_i,
  output logic port_e0_display_data4_pin_o,
  output logic port_e0_display_data4_pin_oe_n_o,
  // clock tree controls
  output crpc_pkg::crpc_clk_en_t clk_en_o,
  output logic hclk_en_o,
  output logic pclk_en_o,
  output logic rtc_tick_o,
  // resets and sdram retention
  output logic sys_rst_o,
  output logic retain_rst_o,
  output logic sdram_self_refresh_o
);

  // elaboration check: the divider needs at least two steps
  if (LP_DIV < 2) begin : g_bad_div
    $error("LP_DIV must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // bus divide code 0..3 to terminal count (ratio - 1)
  function automatic logic [1:0] hdiv_last(input logic [1:0] code);
    hdiv_last = code;
  endfunction : hdiv_last

  // peripheral divide code 0,1,2 to terminal count of 1,3,7 (ratio 2,4,8)
  function automatic logic [2:0] pdiv_last(input logic [1:0] code);
    unique case (code)
      2'h0: pdiv_last = 3'h1;
      2'h1: pdiv_last = 3'h3;
      default: pdiv_last = 3'h7;
    endcase
  endfunction : pdiv_last

  //////////////////////////////////////////////////////////////////////////////
  // reset merge

  logic any_rst; // raw merge of reset inputs
  logic por_act; // power-on reset input active
  logic rel_meta_r; // first synchroniser stage
  logic rel_r; // second synchroniser stage
  logic por_meta_r; // first stage for the retained domain
  logic por_r; // second stage for the retained domain

  assign por_act = !power_on_reset_n_i;
  assign any_rst = por_act || !power_fail_reset_n_i || !user_reset_n_i;

  // assertion is combinational so reset bites with no clock; release is two flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rel_meta_r <= 1'b1;
      rel_r <= 1'b1;
    end
    else
    begin
      rel_meta_r <= any_rst;
      // a live input refills the stretch, so a one-cycle pulse cannot dent sys_rst_o
      rel_r <= rel_meta_r || any_rst;
    end
  end

  // retained registers see only power-on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_meta_r <= 1'b1;
      por_r <= 1'b1;
    end
    else
    begin
      por_meta_r <= por_act;
      por_r <= por_meta_r || por_act;
    end
  end

  assign sys_rst_o = any_rst || rel_r;
  assign retain_rst_o = por_act || por_r;
  // the sdram controller sits in the retained domain, so it still acts on this
  assign sdram_self_refresh_o = power_on_reset_n_i
    && (!power_fail_reset_n_i || !user_reset_n_i);

  logic rst_all; // reset for everything outside the retained domain
  assign rst_all = rst_i || sys_rst_o;

  //////////////////////////////////////////////////////////////////////////////
  // low-power clock edge and 1 Hz ripple divider

  logic lp_q_r; // previous low-power clock sample
  logic lp_edge; // rising edge of the low-power clock
  logic [$clog2(LP_DIV)-1:0] lp_cnt_r; // divider stage count
  logic rtc_tick_r; // one-cycle 1 Hz strobe

  assign lp_edge = lp_osc_i && !lp_q_r;

  // low-power clock sampled each cycle; keeps running through every state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lp_q_r <= 1'b0;
    else
      lp_q_r <= lp_osc_i;
  end

  // the rtc divider is retained: only power-on clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || retain_rst_o)
    begin
      lp_cnt_r <= '0;
      rtc_tick_r <= 1'b0;
    end
    else if (lp_edge)
    begin
      rtc_tick_r <= (lp_cnt_r == ($clog2(LP_DIV))'(LP_DIV - 1));
      if (lp_cnt_r == ($clog2(LP_DIV))'(LP_DIV - 1))
        lp_cnt_r <= '0;
      else
        lp_cnt_r <= lp_cnt_r + 1'b1;
    end
    else
      rtc_tick_r <= 1'b0;
  end

  assign rtc_tick_o = rtc_tick_r;

  //////////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave

  crpc_pkg::crpc_ctrl_t ctrl_r; // divider, gate and display-mode control
  crpc_pkg::crpc_cause_t cause_r; // last reset cause
  logic halt_req_r; // pending software request for halt
  logic stby_req_r; // pending software request for standby
  logic ack_r; // wishbone acknowledge
  logic [31:0] dat_r; // registered read data
  logic wb_req; // new request this cycle
  logic wr_ctrl; // write strobe to control
  logic wr_cmd; // write strobe to command
  logic wr_cause; // write strobe to cause
  crpc_pkg::crpc_state_t state_r; // power state

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == crpc_pkg::OFS_CTRL;
  assign wr_cmd = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == crpc_pkg::OFS_CMD;
  assign wr_cause = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == crpc_pkg::OFS_CAUSE;

  // ack one cycle after the strobe, drop it the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req;
  end

  // read mux; unmapped offsets read zero and are still acked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        crpc_pkg::OFS_CTRL: dat_r <= {26'h0, ctrl_r};
        crpc_pkg::OFS_CMD: dat_r <= {30'h0, stby_req_r, halt_req_r};
        crpc_pkg::OFS_STATUS: dat_r <= {30'h0, state_r};
        crpc_pkg::OFS_CAUSE: dat_r <= {29'h0, cause_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // control register; an illegal peripheral code keeps the old ratio
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      ctrl_r <= crpc_pkg::CTRL_RESET;
    else if (wr_ctrl)
    begin
      ctrl_r.hdiv <= wb_dat_i[1:0];
      if (wb_dat_i[3:2] != crpc_pkg::PDIV_ILLEGAL)
        ctrl_r.pdiv <= wb_dat_i[3:2];
      ctrl_r.hgate <= wb_dat_i[4];
      ctrl_r.lcd8 <= wb_dat_i[5];
    end
  end

  // cause is retained across fail/user resets; a live input beats a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cause_r <= crpc_pkg::CAUSE_RESET;
    else if (por_act)
      cause_r <= 3'h1;
    else
    begin
      cause_r.por <= wr_cause && wb_dat_i[crpc_pkg::CAUSE_POR_BIT] ? 1'b0 : cause_r.por;
      cause_r.pwrfail <= !power_fail_reset_n_i
        || (cause_r.pwrfail && !(wr_cause && wb_dat_i[crpc_pkg::CAUSE_PWRFAIL_BIT]));
      cause_r.user <= !user_reset_n_i
        || (cause_r.user && !(wr_cause && wb_dat_i[crpc_pkg::CAUSE_USER_BIT]));
    end
  end

  // requests wait for the next low-power edge, where the state logic steps
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      halt_req_r <= 1'b0;
      stby_req_r <= 1'b0;
    end
    else
    begin
      halt_req_r <= (wr_cmd && wb_dat_i[crpc_pkg::CMD_HALT_BIT])
        || (halt_req_r && !lp_edge);
      stby_req_r <= (wr_cmd && wb_dat_i[crpc_pkg::CMD_STANDBY_BIT])
        || (stby_req_r && !lp_edge);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power state machine, stepped by the low-power clock

  crpc_pkg::crpc_state_t state_nxt; // next power state

  // standby wins over halt when both are pending
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      crpc_pkg::ST_STANDBY:
        if (wake_i)
          state_nxt = crpc_pkg::ST_RUN;
      crpc_pkg::ST_RUN:
        if (stby_req_r)
          state_nxt = crpc_pkg::ST_STANDBY;
        else if (halt_req_r)
          state_nxt = crpc_pkg::ST_HALT;
      crpc_pkg::ST_HALT:
        if (wake_i)
          state_nxt = crpc_pkg::ST_RUN;
      default:
        state_nxt = crpc_pkg::ST_STANDBY;
    endcase
  end

  // every reset lands in standby, not run
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      state_r <= crpc_pkg::ST_STANDBY;
    else if (lp_edge)
      state_r <= state_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock enables per state

  logic awake; // main oscillator domain alive
  assign awake = state_r != crpc_pkg::ST_STANDBY;

  // registered so the clock tree sees no decode glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      clk_en_o <= '0;
    else
    begin
      clk_en_o.main_osc <= awake;
      clk_en_o.system_pll <= awake;
      clk_en_o.usb_pll <= awake;
      clk_en_o.periph_ref <= awake;
      clk_en_o.prog_div <= awake;
      clk_en_o.core <= state_r == crpc_pkg::ST_RUN;
      clk_en_o.display <= awake;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus and peripheral dividers

  logic [1:0] hcnt_r; // bus divider phase
  logic [1:0] hlast_r; // active bus terminal count
  logic [2:0] pcnt_r; // peripheral divider phase
  logic [2:0] plast_r; // active peripheral terminal count
  logic hrun; // bus clock allowed
  logic hwrap; // bus period ends this cycle
  logic hclk_r; // bus clock strobe
  logic pclk_r; // peripheral clock strobe

  assign hrun = awake && !ctrl_r.hgate;
  assign hwrap = hcnt_r == hlast_r;

  // new ratios load only at a period end, so no short pulse escapes
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      hcnt_r <= 2'h0;
      hlast_r <= 2'h0;
      hclk_r <= 1'b0;
    end
    else
    begin
      hclk_r <= hrun && hwrap;
      if (hwrap)
      begin
        hcnt_r <= 2'h0;
        hlast_r <= hdiv_last(ctrl_r.hdiv);
      end
      else
        hcnt_r <= hcnt_r + 2'h1;
    end
  end

  // peripheral divider counts bus strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      pcnt_r <= 3'h0;
      plast_r <= 3'h1;
      pclk_r <= 1'b0;
    end
    else
    begin
      pclk_r <= hrun && hwrap && pcnt_r == plast_r;
      if (hrun && hwrap)
      begin
        if (pcnt_r == plast_r)
        begin
          pcnt_r <= 3'h0;
          plast_r <= pdiv_last(ctrl_r.pdiv);
        end
        else
          pcnt_r <= pcnt_r + 3'h1;
      end
    end
  end

  assign hclk_en_o = hclk_r;
  assign pclk_en_o = pclk_r;

  //////////////////////////////////////////////////////////////////////////////
  // shared port / display data pin

  // in standby with the 8-bit display the pin is parked low
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      port_e0_display_data4_pin_o <= 1'b0;
      port_e0_display_data4_pin_oe_n_o <= 1'b1;
    end
    else if (!awake && ctrl_r.lcd8)
    begin
      port_e0_display_data4_pin_o <= 1'b0;
      port_e0_display_data4_pin_oe_n_o <= 1'b0;
    end
    else
    begin
      port_e0_display_data4_pin_o <= port_e0_drive_i;
      port_e0_display_data4_pin_oe_n_o <= port_e0_drive_oe_n_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_hdiv2;
    @(posedge clk_i) disable iff (rst_all)
    hclk_en_o && hlast_r == 2'h1 && $stable(hlast_r) && hrun |=> !hclk_en_o;
  endproperty
  a_hdiv2: assert property (p_hdiv2) else $error("bus strobe too close");

  property p_pclk_sub;
    @(posedge clk_i) disable iff (rst_all)
    pclk_en_o |-> hclk_en_o;
  endproperty
  a_pclk_sub: assert property (p_pclk_sub) else $error("peripheral strobe off bus");

  property p_gate;
    @(posedge clk_i) disable iff (rst_all)
    ctrl_r.hgate |=> !hclk_en_o;
  endproperty
  a_gate: assert property (p_gate) else $error("gated bus clock ran");

  property p_rtc;
    @(posedge clk_i) disable iff (rst_i || retain_rst_o)
    rtc_tick_o |-> $past(lp_edge) && lp_cnt_r == '0;
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc tick not at wrap");

  property p_core;
    @(posedge clk_i) disable iff (rst_all)
    clk_en_o.core |-> $past(state_r) == crpc_pkg::ST_RUN;
  endproperty
  a_core: assert property (p_core) else $error("core clocked outside run");

  property p_stby;
    @(posedge clk_i) disable iff (rst_all)
    state_r == crpc_pkg::ST_STANDBY |=> !clk_en_o.main_osc && !clk_en_o.display;
  endproperty
  a_stby: assert property (p_stby) else $error("standby left clocks on");

  property p_rst;
    @(posedge clk_i) any_rst |-> sys_rst_o ##1 sys_rst_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset input not merged");

  property p_rel;
    @(posedge clk_i) disable iff (rst_i)
    $fell(sys_rst_o) |-> state_r == crpc_pkg::ST_STANDBY;
  endproperty
  a_rel: assert property (p_rel) else $error("reset left not in standby");

  property p_sref;
    @(posedge clk_i) disable iff (rst_i)
    (!user_reset_n_i || !power_fail_reset_n_i) && power_on_reset_n_i
      |-> sdram_self_refresh_o && !retain_rst_o;
  endproperty
  a_sref: assert property (p_sref) else $error("self refresh missing");

  property p_cause;
    @(posedge clk_i) disable iff (rst_i || por_act)
    !power_fail_reset_n_i |=> cause_r.pwrfail;
  endproperty
  a_cause: assert property (p_cause) else $error("fail cause not recorded");

  property p_pin;
    @(posedge clk_i) disable iff (rst_all)
    !awake && ctrl_r.lcd8 |=> !port_e0_display_data4_pin_oe_n_o
      && !port_e0_display_data4_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not parked low");

endmodule : crpc_top
`default_nettype wire

/* File: tb/crpc_lp_osc_model.sv */
// low-power oscillator model feeding the controller's sampled lp input
`timescale 1ns/1ps
`default_nettype none
module crpc_lp_osc_model #(
  parameter int HALF = 8 // half period in system clocks
) (
  input wire logic clk_i,
  output logic lp_osc_o
);
  // phase counter; no reset reaches it, the oscillator never stops
  int cnt_r = 0;
  logic osc_r = 1'b0; // square wave level
  ////////////////////////////////////////////////////////////////////////////
  // toggle every HALF clocks so each period is exactly 2*HALF clocks
  always_ff @(posedge clk_i)
  begin
    if (cnt_r == HALF - 1)
    begin
      cnt_r <= 0;
      osc_r <= ~osc_r;
    end
    else
    begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign lp_osc_o = osc_r;
endmodule : crpc_lp_osc_model
`default_nettype wire

/* File: tb/test_clock_power_reset_controller.sv */
// self-checking bench for the clock, power-state and reset controller
`timescale 1ns/1ps
`default_nettype none
module test_clock_power_reset_controller;
  localparam int HALF = 8; // lp half period in clocks
  localparam int LPD = 4; // shortened rtc divide, keeps the run short
  localparam int LP_WAIT = 48; // three lp periods, enough for one state step
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic wb_ack_o, lp_osc, pin_o, pin_oe_n;
  logic por_n = 1'b1, pf_n = 1'b1, ur_n = 1'b1; // external resets, idle high
  logic wake = 1'b0, pin_drv = 1'b0, pin_drv_oe_n = 1'b1;
  crpc_pkg::crpc_clk_en_t clk_en_o;
  logic hclk_en_o, pclk_en_o, rtc_tick_o, sys_rst_o, retain_rst_o, sdram_self_refresh_o;
  int errors = 0;
  int check_count = 0;
  int m_state = 0; // model of the power state code
  int g; // measured gap in clocks
  int m_cause[$]; // model of recorded reset causes, oldest first
  logic [31:0] lfsr = 32'h0260B7B4;
  ////////////////////////////////////////////////////////////////////////////
  crpc_lp_osc_model #(.HALF(HALF)) crpc_lp_osc_model_i (.clk_i(clk_i), .lp_osc_o(lp_osc));
  crpc_top #(.LP_DIV(LPD)) crpc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .power_on_reset_n_i(por_n), .power_fail_reset_n_i(pf_n),
    .user_reset_n_i(ur_n), .lp_osc_i(lp_osc), .wake_i(wake), .port_e0_drive_i(pin_drv),
    .port_e0_drive_oe_n_i(pin_drv_oe_n), .port_e0_display_data4_pin_o(pin_o),
    .port_e0_display_data4_pin_oe_n_o(pin_oe_n), .clk_en_o(clk_en_o),
    .hclk_en_o(hclk_en_o), .pclk_en_o(pclk_en_o), .rtc_tick_o(rtc_tick_o),
    .sys_rst_o(sys_rst_o), .retain_rst_o(retain_rst_o),
    .sdram_self_refresh_o(sdram_self_refresh_o)
  );
  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // x-safe compare, counted
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // classic single cycle; holds everything until ack is sampled, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= dat;
    do
    begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    // the slave must drop ack the cycle after it gave it
    @(posedge clk_i);
    check("ack drop", wb_ack_o, 1'b0);
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(name, d, exp);
  endtask : rd_chk
  function automatic logic pulse(input int s);
    return (s == 0) ? hclk_en_o : (s == 1) ? pclk_en_o : rtc_tick_o;
  endfunction : pulse
  // stimulus source: one step of the bench's shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // clocks between the 2nd and 3rd strobe, past any ratio change
  task automatic measure(input int s, output int n);
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end while (pulse(s) !== 1'b1 && n < 600);
    end
  endtask : measure
  // wake level held over a state step, then dropped
  task automatic go_run;
    wake <= 1'b1;
    repeat (LP_WAIT) @(posedge clk_i);
    wake <= 1'b0;
    m_state = 1;
    repeat (2) @(posedge clk_i);
  endtask : go_run
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    check("sys_rst in reset", sys_rst_o, 1'b1);
    check("pin oe in reset", pin_oe_n, 1'b1);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("sys_rst released", sys_rst_o, 1'b0);
    rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
    check("standby osc", clk_en_o.main_osc, 1'b0);
    check("standby display", clk_en_o.display, 1'b0);
    lfsr = lfsr_next(lfsr);
    wr(8'h40, lfsr);
    rd_chk("unmapped", 8'h40, 32'h0);
    measure(2, g);
    check("rtc gap", g, LPD * 2 * HALF);
    go_run();
    rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
    check("run enables", clk_en_o, 7'h7F);
    for (int h = 0; h < 4; h++)
      for (int p = 0; p < 3; p++)
      begin
        wr(crpc_pkg::OFS_CTRL, 32'(p * 4 + h));
        measure(0, g);
        check("hclk gap", g, h + 1);
        measure(1, g);
        check("pclk gap", g, (h + 1) * (2 << p));
      end
    wr(crpc_pkg::OFS_CTRL, 32'h0F);
    rd_chk("ctrl", crpc_pkg::OFS_CTRL, 32'h0B);
    measure(1, g);
    check("pclk kept", g, 32);
    wr(crpc_pkg::OFS_CTRL, 32'h10);
    repeat (8) @(posedge clk_i);
    g = 0;
    repeat (20)
    begin
      @(posedge clk_i);
      if (hclk_en_o !== 1'b0)
        g++;
    end
    check("gated hclk", g, 0);
    lfsr = lfsr_next(lfsr);
    pin_drv <= lfsr[0];
    pin_drv_oe_n <= lfsr[1];
    wr(crpc_pkg::OFS_CTRL, 32'h20);
    repeat (3) @(posedge clk_i);
    check("pin run", pin_o, lfsr[0]);
    check("pin oe run", pin_oe_n, lfsr[1]);
    wr(crpc_pkg::OFS_CMD, 32'h1 << crpc_pkg::CMD_HALT_BIT);
    repeat (LP_WAIT) @(posedge clk_i);
    m_state = 3;
    rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
    check("halt core", clk_en_o.core, 1'b0);
    check("halt osc", clk_en_o.main_osc, 1'b1);
    measure(0, g);
    check("halt hclk", g, 1);
    go_run();
    rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
    wr(crpc_pkg::OFS_CMD, 32'h1 << crpc_pkg::CMD_STANDBY_BIT);
    repeat (LP_WAIT) @(posedge clk_i);
    m_state = 0;
    rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
    check("standby osc", clk_en_o.main_osc, 1'b0);
    check("standby display", clk_en_o.display, 1'b0);
    check("pin standby", pin_o, 1'b0);
    check("pin oe standby", pin_oe_n, 1'b0);
    wr(crpc_pkg::OFS_CAUSE, 32'h7);
    for (int k = 0; k < 3; k++)
    begin
      go_run();
      @(posedge clk_i);
      por_n <= (k != 0);
      pf_n <= (k != 1);
      ur_n <= (k != 2);
      m_cause.push_back(1 << k);
      #1;
      check("sys_rst", sys_rst_o, 1'b1);
      check("retain_rst", retain_rst_o, k == 0);
      check("self_refresh", sdram_self_refresh_o, k != 0);
      @(posedge clk_i);
      por_n <= 1'b1;
      pf_n <= 1'b1;
      ur_n <= 1'b1;
      @(posedge clk_i);
      #1;
      check("sys_rst hold", sys_rst_o, 1'b1);
      @(posedge clk_i);
      #1;
      check("sys_rst free", sys_rst_o, 1'b0);
      m_state = 0;
      rd_chk("cause", crpc_pkg::OFS_CAUSE, 32'(m_cause.pop_front()));
      rd_chk("status", crpc_pkg::OFS_STATUS, 32'(m_state));
      wr(crpc_pkg::OFS_CAUSE, 32'h7);
      rd_chk("cause clear", crpc_pkg::OFS_CAUSE, 32'h0);
    end
    print_verdict();
  end
  // cuts a hang short
  initial
  begin
    #(40000 * 50);
    errors++;
    print_verdict();
  end
endmodule : test_clock_power_reset_controller
`default_nettype wire
